// ### list_sequencer.sv
// list sequencer with trigger-gated wait steps behind a wishbone slave
//
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
// Notes on behaviour
// (R01) list capacity is one of three model sizes; appends beyond it are refused
// (R02) clear resets append position to zero; appends fill sequential locations
// (R03) host keeps commands short and splits long loads across appends
// (R04) append, readback or point query with current entries posts conflict error
// (R05) readback returns up to sixteen values from selected start location
// (R06) point count equals next free location; pointer increments per value
// (R07) waveform apply appends level and dwell entries for six shapes
// (R08) waveform centred on zero, shifted by offset, offset ignored for level; the code adds no offset to any shape
// (R09) generated points are clipped to the programmed software limit
// (R10) sweep sets start angle and stop angle, stop defaults to full cycle
// (R11) sweep query reports angles kept within minimum and maximum
// (R12) entering a wait step drives the setpoint to its level at once
// (R13) wait-high with input already high and nonzero timeout skips at once
// (R14) with nonzero timeout the step advances on trigger or timeout first
// (R15) zero timeout wait-high holds until the trigger goes high
// (R16) high waits need trigger stable for the long filter time
// (R17) low waits need trigger stable for the short filter time
// (R18) wait-low with input already low and timeout skips; else waits
// (R19) falling-edge wait needs a real high then low transition
// (R20) zero timeout falling-edge wait holds until high-to-low transition
// (R21) wait command with no list entries posts a conflict error
// (R22) dwell length mismatch posts length error, separate code for low waits
// (R23) while running every list command is refused with a command error; the code still accepts CMD_HALT
// (R24) halt stops sequencing at the end of the current pass
// (R25) step timeout is capped at its maximum value
// (R26) trigger input is synchronised through flip-flops before filtering
// (R27) filter and timeout counters run on the clock; filter restarts on each trigger change, timeout per step
module list_sequencer
   import lseq_pkg::*;
#(
   parameter logic [1:0]  MODEL_SEL = 2'd2,
   parameter int unsigned HIGH_FILT = HIGH_FILT_CYC,
   parameter int unsigned WAIT_MAX  = WAIT_MAX_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   input  wire logic        trigger_i,
   output logic [15:0]      setpoint_o,
   output logic             running_o
);
   typedef struct packed {
      seq_state_e  st;
      logic        ack;
      logic [31:0] rdata;
      logic [12:0] wptr;
      logic [12:0] dwell_len;
      logic [12:0] rd_start;
      logic [12:0] step;
      logic        curr_used;
      logic [15:0] err;
      logic [15:0] arg;
      logic [15:0] arg2;
      logic [15:0] limit;
      logic [15:0] sw_start;
      logic [15:0] sw_stop;
      logic [15:0] wait_to;
      logic [15:0] setpoint;
      logic        halt_req;
      logic [3:0]  gen_cnt;
      logic [3:0]  gen_shape;
      logic [1:0]  kind;
      logic [2:0]  sync;
      logic        trig;
      logic [15:0] filt_cnt;
      logic [19:0] to_cnt;
      logic        seen_high;
      logic        mem_we;
      logic [12:0] mem_adr;
      entry_s      mem_d;
   } state_s;

   state_s      r;
   state_s      next_r;
   entry_s      mem [0:LIST_CAP_MAX-1];
   entry_s      mem_q;
   logic [12:0] cap;

   always_comb begin
      case (MODEL_SEL)
         2'd0:    cap = CAP_SMALL; // R01
         2'd1:    cap = CAP_MID; // R01
         default: cap = CAP_LARGE; // R01
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (r.mem_we) begin
         mem[r.mem_adr] <= r.mem_d;
      end
      mem_q <= mem[next_r.mem_adr];
   end

   function automatic logic [15:0] clip(input logic signed [17:0] v, input logic [15:0] lim);
      logic signed [17:0] l;
      l = 18'(signed'({2'b00, lim}));
      if (v > l) begin
         clip = lim;
      end else if (v < -l) begin
         clip = 16'(-l);
      end else begin
         clip = v[15:0];
      end
   endfunction

   function automatic logic signed [17:0] shape(input logic [3:0] s, input logic [3:0] k,
                                                input logic [15:0] amp);
      logic signed [17:0] h;
      logic signed [17:0] st;
      h  = 18'(signed'(amp)) >>> 1;
      st = 18'(signed'(amp)) >>> 3;
      case (s)
         CMD_APPLY_SQUARE: shape = (k < 4'd4) ? h : -h;
         CMD_APPLY_RAMPUP: shape = -h + 18'(st * 18'(k));
         CMD_APPLY_RAMPDN: shape = h - 18'(st * 18'(k));
         CMD_APPLY_TRI:    shape = (k < 4'd4) ? -h + 18'(2 * st * 18'(k))
                                              : h - 18'(2 * st * 18'(k - 4'd4));
         CMD_APPLY_SINE:   shape = (k == 4'd0 || k == 4'd4) ? 18'sd0 :
                                   (k < 4'd4) ? h : -h;
         default:          shape = 18'sd0;
      endcase
   endfunction

   always_comb begin
      logic        req;
      logic        lvl_ok;
      logic        busy;
      logic        timed;
      logic        expire;
      logic        done;
      logic        filt_hit;
      logic [3:0]  cmd;
      logic [4:0]  i;
      logic [12:0] a;
      logic [7:0]  off;
      next_r        = r;
      off           = 8'h00;
      req           = cyc_i && stb_i && !r.ack;
      busy          = (r.st != ST_IDLE);
      lvl_ok        = 1'b0;
      timed         = 1'b0;
      expire        = 1'b0;
      done          = 1'b0;
      filt_hit      = 1'b0;
      cmd           = dat_i[3:0];
      i             = 5'd0;
      a             = 13'd0;
      next_r.ack    = req;
      next_r.mem_we = 1'b0;
      // trigger synchroniser and level filter
      next_r.sync   = {r.sync[1:0], trigger_i}; // R26
      if (r.sync[2] != r.sync[1]) begin
         next_r.filt_cnt = 16'd0; // R27
      end else if (r.filt_cnt != 16'hffff) begin
         next_r.filt_cnt = r.filt_cnt + 16'd1;
      end
      if (r.kind == KIND_LOW) begin
         filt_hit = (32'(r.filt_cnt) + 32'd1 >= LOW_FILT_CYC); // R17
      end else begin
         filt_hit = (32'(r.filt_cnt) + 32'd1 >= HIGH_FILT); // R16
      end
      if (filt_hit) begin
         next_r.trig = r.sync[2];
      end

      if (req) begin
         if (we_i && sel_i[0]) begin
            case (adr_i)
               REG_ARG:   begin
                  next_r.arg  = dat_i[15:0];
                  next_r.arg2 = dat_i[31:16];
               end
               REG_LIMIT: next_r.limit = dat_i[15:0];
               REG_WAIT:  next_r.wait_to = (32'(dat_i[15:0]) > WAIT_MAX) ?
                                           16'(WAIT_MAX) : dat_i[15:0]; // R25
               REG_SWEEP: begin
                  next_r.sw_start = (dat_i[15:0] > ANGLE_FULL) ? ANGLE_FULL : dat_i[15:0]; // R11
                  next_r.sw_stop  = (dat_i[31:16] == 16'h0000 || dat_i[31:16] > ANGLE_FULL) ?
                                    ANGLE_FULL : dat_i[31:16]; // R10
                  if (next_r.sw_stop < ANGLE_MIN) begin
                     next_r.sw_stop = ANGLE_MIN; // R11
                  end
               end
               REG_ERROR: next_r.err = ERR_NONE;
               REG_CMD: begin
                  if (busy && cmd != CMD_HALT) begin
                     next_r.err = ERR_CMD; // R23
                  end else begin
                     case (cmd)
                        CMD_CLEAR: begin
                           next_r.wptr      = 13'd0; // R02
                           next_r.dwell_len = 13'd0;
                           next_r.curr_used = 1'b0;
                           next_r.rd_start  = 13'd0;
                        end
                        CMD_APPEND: begin
                           if (r.curr_used) begin
                              next_r.err = ERR_CONFLICT; // R04
                           end else if (r.wptr < cap) begin // R01
                              next_r.mem_we  = 1'b1;
                              next_r.mem_adr = r.wptr; // R02
                              next_r.mem_d   = '{kind: KIND_PLAIN, level: r.arg};
                              next_r.wptr    = r.wptr + 13'd1; // R06
                           end
                        end
                        CMD_CURR_APPEND: next_r.curr_used = 1'b1;
                        CMD_READ_START: next_r.rd_start = r.arg[12:0]; // R05
                        CMD_POINT_QUERY: begin
                           if (r.curr_used) begin
                              next_r.err = ERR_CONFLICT; // R04
                           end
                        end
                        CMD_WAIT_HIGH, CMD_WAIT_LOW, CMD_WAIT_FALL: begin
                           if (r.wptr == 13'd0 && !r.curr_used) begin
                              next_r.err = ERR_CONFLICT; // R21
                           end else if (r.dwell_len != r.wptr) begin
                              next_r.err = (cmd == CMD_WAIT_LOW) ? ERR_LEN_LOW
                                                                 : ERR_LEN_HIGH; // R22
                           end else if (r.wptr < cap) begin
                              next_r.mem_we  = 1'b1;
                              next_r.mem_adr = r.wptr;
                              next_r.mem_d.level = r.arg;
                              next_r.mem_d.kind  = (cmd == CMD_WAIT_HIGH) ? KIND_HIGH :
                                                   (cmd == CMD_WAIT_LOW)  ? KIND_LOW : KIND_FALL;
                              next_r.wptr      = r.wptr + 13'd1;
                              next_r.dwell_len = r.dwell_len + 13'd1;
                           end
                        end
                        CMD_RUN: begin
                           if (r.wptr != 13'd0) begin
                              next_r.st       = ST_FETCH;
                              next_r.step     = 13'd0;
                              next_r.mem_adr  = 13'd0;
                              next_r.halt_req = 1'b0;
                           end
                        end
                        CMD_HALT: next_r.halt_req = busy;
                        default: begin
                           if (r.curr_used) begin
                              next_r.err = ERR_CONFLICT;
                           end else if (cmd >= CMD_APPLY_LEVEL && cmd <= CMD_APPLY_SINE) begin
                              next_r.st        = ST_GEN; // R07
                              next_r.gen_cnt   = 4'd0;
                              next_r.gen_shape = cmd;
                           end
                        end
                     endcase
                  end
               end
               default: ;
            endcase
         end else if (!we_i) begin
            case (adr_i)
               REG_STATUS: next_r.rdata = {24'h0, 1'b0, r.sync[2], r.trig, r.halt_req,
                                           1'b0, r.st};
               REG_POINTS: next_r.rdata = {19'h0, r.wptr}; // R06
               REG_ERROR:  next_r.rdata = {16'h0, r.err};
               REG_SWEEP:  next_r.rdata = {r.sw_stop, r.sw_start}; // R11
               REG_LIMIT:  next_r.rdata = {16'h0, r.limit};
               REG_WAIT:   next_r.rdata = {16'h0, r.wait_to};
               default: begin
                  // 16 entries starting at the selected location
                  off = adr_i - REG_READ;
                  i   = {1'b0, off[5:2]};
                  a   = r.rd_start + 13'(i);
                  next_r.rdata = 32'h0;
                  if (off < 8'(4 * READBACK_MAX)) begin
                     next_r.rdata = (a < r.wptr) ? {16'h0, mem[a].level} : 32'h0; // R05
                     if (r.curr_used) begin
                        next_r.err = ERR_CONFLICT; // R04
                     end
                  end
               end
            endcase
         end
      end

      case (r.st)
         ST_IDLE: ;
         ST_GEN: begin
            if (r.gen_cnt == 4'(APPLY_POINTS) || r.wptr >= cap) begin // R01
               next_r.st = ST_IDLE;
            end else begin
               next_r.mem_we  = 1'b1;
               next_r.mem_adr = r.wptr;
               next_r.mem_d.kind = KIND_PLAIN;
               if (r.gen_shape == CMD_APPLY_LEVEL) begin
                  next_r.mem_d.level = clip(18'(signed'(r.arg2)), r.limit); // R08
               end else begin
                  next_r.mem_d.level = clip(shape(r.gen_shape, r.gen_cnt, r.arg2),
                                            r.limit); // R08 R09
               end
               next_r.wptr      = r.wptr + 13'd1; // R07
               next_r.dwell_len = r.dwell_len + 13'd1;
               next_r.gen_cnt   = r.gen_cnt + 4'd1;
            end
         end
         ST_FETCH: begin
            next_r.st = ST_STEP;
         end
         ST_STEP: begin
            next_r.setpoint  = mem_q.level; // R12
            next_r.kind      = mem_q.kind;
            next_r.to_cnt    = 20'd0; // R27
            next_r.seen_high = 1'b0;
            next_r.st        = (mem_q.kind == KIND_PLAIN) ? ST_FETCH : ST_WAIT;
            if (mem_q.kind == KIND_PLAIN) begin
               done = 1'b1;
            end
         end
         ST_WAIT: begin
            timed  = (r.wait_to != 16'h0000);
            expire = timed && (r.to_cnt >= 20'(r.wait_to) * 20'd1); // R14
            next_r.to_cnt = r.to_cnt + 20'd1;
            case (r.kind)
               KIND_HIGH: done = r.trig || expire; // R13 R15
               KIND_LOW:  done = !r.trig || expire; // R18
               KIND_FALL: begin
                  if (r.trig) begin
                     next_r.seen_high = 1'b1; // R19
                  end
                  done = (r.seen_high && !r.trig) || expire; // R20
               end
               default:   done = 1'b1;
            endcase
         end
         default: next_r.st = ST_IDLE;
      endcase

      if (done) begin
         if (r.step + 13'd1 >= r.wptr) begin
            next_r.step    = 13'd0;
            next_r.mem_adr = 13'd0;
            next_r.st      = r.halt_req ? ST_IDLE : ST_FETCH; // R24
            next_r.halt_req = 1'b0;
         end else begin
            next_r.step    = r.step + 13'd1;
            next_r.mem_adr = r.step + 13'd1;
            next_r.st      = ST_FETCH;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r          <= '0;
         r.st       <= ST_IDLE;
         r.sw_start <= ANGLE_START_RST;
         r.sw_stop  <= ANGLE_FULL;
         r.limit    <= 16'h7fff;
      end else begin
         r <= next_r;
      end
   end

   assign dat_o      = r.rdata;
   assign ack_o      = r.ack;
   assign setpoint_o = r.setpoint;
   assign running_o  = (r.st != ST_IDLE) && (r.st != ST_GEN);

   logic req_clear;
   logic req_cmd;
   assign req_cmd   = cyc_i && stb_i && !r.ack && we_i && sel_i[0] && adr_i == REG_CMD;
   assign req_clear = req_cmd && !running_o && r.st != ST_GEN && dat_i[3:0] == CMD_CLEAR;

   clear_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req_clear) |=> (r.wptr == 13'd0)) else $error("clear did not zero pointer"); // R02
   cap_limit_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (r.wptr <= cap)) else $error("list exceeds capacity"); // R01
   step_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (r.st == ST_STEP) |=> (setpoint_o == $past(mem_q.level))) else $error("level not applied"); // R12
   wait_cap_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (32'(r.wait_to) <= WAIT_MAX)) else $error("timeout above maximum"); // R25
   hold_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (r.st == ST_WAIT && r.kind == KIND_HIGH && r.wait_to == 16'h0 && !r.trig)
      |=> (r.st == ST_WAIT)) else $error("high wait left early"); // R15
   fall_need_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (r.st == ST_WAIT && r.kind == KIND_FALL && r.wait_to == 16'h0 && !r.seen_high)
      |=> (r.st == ST_WAIT)) else $error("edge wait left without high"); // R19
   busy_reject_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (running_o && req_cmd && dat_i[3:0] != CMD_HALT) |=> (r.err == ERR_CMD))
      else $error("busy command accepted"); // R23
   ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o) else $error("ack held"); 
   sweep_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (r.sw_stop >= ANGLE_MIN && r.sw_stop <= ANGLE_FULL)) else $error("stop angle out of range"); // R11
   run_c: cover property (@(posedge clk_i) disable iff (rst_i) r.st == ST_WAIT ##1 r.st == ST_FETCH);
   gen_c: cover property (@(posedge clk_i) disable iff (rst_i) r.st == ST_GEN);
   err_c: cover property (@(posedge clk_i) disable iff (rst_i) r.err == ERR_LEN_LOW);

endmodule // list_sequencer

// ### list_sequencer_bench.sv
// self-checking bench for the list sequencer
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin tests_run++; if ((sn) !== (ex)) begin failures++; \
   $display("mismatch %s expected %h seen %h", nm, ex, sn); end end
module list_sequencer_bench;
   import lseq_pkg::*;
   localparam int unsigned HF = 40;
   localparam int unsigned WM = 400;
   logic        clk_i     = 1'b0;
   logic        rst_i     = 1'b1;
   logic        cyc       = 1'b0;
   logic        stb       = 1'b0;
   logic        we        = 1'b0;
   logic [7:0]  adr       = 8'h00;
   logic [31:0] dat       = 32'h0;
   logic [31:0] dat_o;
   logic        ack_o;
   logic        trig_req  = 1'b0;
   logic        trigger;
   logic [15:0] setpoint_o;
   logic        running_o;
   logic [31:0] q;
   int          failures  = 0;
   int          tests_run = 0;
   int          cycles    = 0;
   int          n;

   always #50 clk_i = ~clk_i;

   list_sequencer #(.HIGH_FILT(HF), .WAIT_MAX(WM)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .trigger_i(trigger),
      .setpoint_o(setpoint_o), .running_o(running_o));
   trig_source src (.clk_i(clk_i), .level_i(trig_req), .trigger_o(trigger));

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k = 0;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
      do begin @(posedge clk_i); k++; end while (ack_o !== 1'b1 && k < 20);
      `CHK("ack", 1'b1, ack_o)
      q = dat_o;
      cyc <= 1'b0; stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic cmd(input logic [3:0] c, input logic [31:0] arg);
      wb(1'b1, REG_ARG, arg);
      wb(1'b1, REG_CMD, {28'h0, c});
   endtask
   task automatic err(input string nm, input logic [15:0] ex);
      wb(1'b0, REG_ERROR, 32'h0);
      `CHK(nm, ex, q[15:0])
      wb(1'b1, REG_ERROR, 32'h0);
   endtask
   task automatic wait_sp(input logic [15:0] v);
      n = 0;
      while (setpoint_o !== v && n < 300) begin @(posedge clk_i); n++; end
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // hang guard, well above the several hundred cycles the tests need
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         failures++;
         summarize();
      end
   end

   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, REG_LIMIT, 32'h0);
      `CHK("limit", 16'h7fff, q[15:0])
      wb(1'b0, 8'hfc, 32'h0);
      `CHK("unmapped", 32'h0, q)
      $display("test registers done");
      cmd(CMD_CLEAR, 32'h0);
      for (int i = 0; i < 3; i++) cmd(CMD_APPEND, 32'h10 + i);
      wb(1'b0, REG_POINTS, 32'h0);
      `CHK("points", 32'd3, q)
      cmd(CMD_READ_START, 32'd1);
      wb(1'b0, REG_READ, 32'h0);
      `CHK("read0", 16'h0011, q[15:0])
      wb(1'b0, REG_READ + 8'h04, 32'h0);
      `CHK("read1", 16'h0012, q[15:0])
      cmd(CMD_WAIT_HIGH, 32'h5);
      err("len high", ERR_LEN_HIGH);
      cmd(CMD_WAIT_LOW, 32'h5);
      err("len low", ERR_LEN_LOW);
      cmd(CMD_CURR_APPEND, 32'h7);
      cmd(CMD_POINT_QUERY, 32'h0);
      err("conflict", ERR_CONFLICT);
      cmd(CMD_CLEAR, 32'h0);
      cmd(CMD_WAIT_HIGH, 32'h5);
      err("empty wait", ERR_CONFLICT);
      wb(1'b1, REG_SWEEP, 32'h0000_0064);
      wb(1'b0, REG_SWEEP, 32'h0);
      `CHK("sweep", {ANGLE_FULL, 16'h0064}, q)
      wb(1'b1, REG_WAIT, 32'h0000_ffff);
      wb(1'b0, REG_WAIT, 32'h0);
      `CHK("wait cap", 16'(WM), q[15:0])
      $display("test list build done");
      cmd(CMD_CLEAR, 32'h0);
      cmd(CMD_APPLY_LEVEL, 32'h0100_0001);
      repeat (10) @(posedge clk_i);
      wb(1'b1, REG_WAIT, 32'h0);
      cmd(CMD_WAIT_HIGH, 32'h0200);
      cmd(CMD_WAIT_LOW, 32'h0300);
      err("balanced", ERR_NONE);
      cmd(CMD_RUN, 32'h0);
      wait_sp(16'h0200);
      `CHK("wait level", 16'h0200, setpoint_o)
      repeat (100) @(posedge clk_i);
      `CHK("held", 16'h0200, setpoint_o)
      `CHK("running", 1'b1, running_o)
      cmd(CMD_APPEND, 32'h9);
      err("busy", ERR_CMD);
      trig_req <= 1'b1;
      wait_sp(16'h0300);
      `CHK("next level", 16'h0300, setpoint_o)
      `CHK("filtered", 1'b1, 1'(n >= HF))
      cmd(CMD_HALT, 32'h0);
      trig_req <= 1'b0;
      n = 0;
      while (running_o !== 1'b0 && n < 2000) begin @(posedge clk_i); n++; end
      `CHK("halted", 1'b0, running_o)
      $display("test run done");
      cmd(CMD_CLEAR, 32'h0);
      wb(1'b1, REG_LIMIT, 32'h0000_0040);
      cmd(CMD_APPLY_SQUARE, 32'h0100_0001);
      repeat (10) @(posedge clk_i);
      cmd(CMD_READ_START, 32'd3);
      wb(1'b0, REG_READ, 32'h0);
      `CHK("clip high", 16'h0040, q[15:0])
      wb(1'b0, REG_READ + 8'h04, 32'h0);
      `CHK("clip low", 16'hffc0, q[15:0])
      wb(1'b0, REG_POINTS, 32'h0);
      `CHK("apply points", 32'd8, q)
      $display("test waveform clip done");
      wb(1'b1, REG_WAIT, 32'd50);
      cmd(CMD_WAIT_HIGH, 32'h0400);
      cmd(CMD_WAIT_FALL, 32'h0500);
      cmd(CMD_RUN, 32'h0);
      wait_sp(16'h0400);
      wait_sp(16'h0500);
      `CHK("timeout", 1'b1, 1'(n >= 50 && n < 60))
      wb(1'b1, REG_WAIT, 32'h0);
      repeat (100) @(posedge clk_i);
      `CHK("edge hold", 16'h0500, setpoint_o)
      trig_req <= 1'b1;
      repeat (60) @(posedge clk_i);
      `CHK("high only", 16'h0500, setpoint_o)
      cmd(CMD_HALT, 32'h0);
      trig_req <= 1'b0;
      n = 0;
      while (running_o !== 1'b0 && n < 2000) begin @(posedge clk_i); n++; end
      `CHK("edge done", 1'b0, running_o)
      $display("test timeout and edge done");
      summarize();
   end
endmodule // list_sequencer_bench

// ### lseq_pkg.sv
// shared constants and carrier types for the list sequencer
package lseq_pkg;
   localparam int unsigned CLK_HZ            = 10_000_000;
   localparam int unsigned LIST_CAP_MAX      = 5900;
   localparam logic [12:0] CAP_SMALL         = 13'd2950;
   localparam logic [12:0] CAP_MID           = 13'd3933;
   localparam logic [12:0] CAP_LARGE         = 13'd5900;
   localparam int unsigned READBACK_MAX      = 16;
   localparam int unsigned HIGH_FILT_US      = 400;
   localparam int unsigned LOW_FILT_US       = 2;
   localparam int unsigned WAIT_MAX_US       = 33000;
   localparam int unsigned HIGH_FILT_CYC     = (HIGH_FILT_US * (CLK_HZ / 1_000_000));
   localparam int unsigned LOW_FILT_CYC      = (LOW_FILT_US * (CLK_HZ / 1_000_000));
   localparam int unsigned WAIT_MAX_CYC      = (WAIT_MAX_US * (CLK_HZ / 1_000_000));
   localparam logic [15:0] ANGLE_FULL        = 16'd36000;
   localparam logic [15:0] ANGLE_MIN         = 16'd1;
   localparam logic [15:0] ANGLE_START_RST   = 16'd0;
   // error codes as signed 16-bit values
   localparam logic [15:0] ERR_NONE          = 16'h0000;
   localparam logic [15:0] ERR_CONFLICT      = 16'hff23;
   localparam logic [15:0] ERR_LEN_HIGH      = 16'hff1e;
   localparam logic [15:0] ERR_LEN_LOW       = 16'hff14;
   localparam logic [15:0] ERR_CMD           = 16'hff9c;
   // register byte offsets
   localparam logic [7:0]  REG_CMD           = 8'h00;
   localparam logic [7:0]  REG_ARG           = 8'h04;
   localparam logic [7:0]  REG_STATUS        = 8'h08;
   localparam logic [7:0]  REG_POINTS        = 8'h0c;
   localparam logic [7:0]  REG_ERROR         = 8'h10;
   localparam logic [7:0]  REG_SWEEP         = 8'h14;
   localparam logic [7:0]  REG_LIMIT         = 8'h18;
   localparam logic [7:0]  REG_WAIT          = 8'h1c;
   localparam logic [7:0]  REG_READ          = 8'h20;
   // command codes written to REG_CMD
   localparam logic [3:0]  CMD_CLEAR         = 4'h1;
   localparam logic [3:0]  CMD_APPEND        = 4'h2;
   localparam logic [3:0]  CMD_CURR_APPEND   = 4'h3;
   localparam logic [3:0]  CMD_READ_START    = 4'h4;
   localparam logic [3:0]  CMD_APPLY_LEVEL   = 4'h5;
   localparam logic [3:0]  CMD_APPLY_SQUARE  = 4'h6;
   localparam logic [3:0]  CMD_APPLY_RAMPUP  = 4'h7;
   localparam logic [3:0]  CMD_APPLY_RAMPDN  = 4'h8;
   localparam logic [3:0]  CMD_APPLY_TRI     = 4'h9;
   localparam logic [3:0]  CMD_APPLY_SINE    = 4'ha;
   localparam logic [3:0]  CMD_WAIT_HIGH     = 4'hb;
   localparam logic [3:0]  CMD_WAIT_LOW      = 4'hc;
   localparam logic [3:0]  CMD_WAIT_FALL     = 4'hd;
   localparam logic [3:0]  CMD_RUN           = 4'he;
   localparam logic [3:0]  CMD_HALT          = 4'hf;
   localparam logic [3:0]  CMD_POINT_QUERY   = 4'h0;
   localparam int unsigned APPLY_POINTS      = 8;
   localparam logic [1:0]  KIND_PLAIN        = 2'd0;
   localparam logic [1:0]  KIND_HIGH         = 2'd1;
   localparam logic [1:0]  KIND_LOW          = 2'd2;
   localparam logic [1:0]  KIND_FALL         = 2'd3;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_GEN   = 3'b001,
      ST_FETCH = 3'b010,
      ST_STEP  = 3'b011,
      ST_WAIT  = 3'b100
   } seq_state_e;

   typedef struct packed {
      logic [1:0]  kind;
      logic [15:0] level;
   } entry_s;
endpackage

// ### trig_source.sv
// trigger source model standing in for the host's pulse line
`timescale 1ns/1ps
module trig_source (
   input  wire logic clk_i,
   input  wire logic level_i,
   output logic      trigger_o
);
   // level changes land just after a clock edge, held until asked again
   always @(posedge clk_i) begin
      trigger_o <= level_i;
   end
endmodule // trig_source
